// ==== hw/tec_cfg.svh ====
// Register map, field positions, reset values and divider settings of the timer block
`ifndef TEC_CFG_SVH
`define TEC_CFG_SVH

// ========
// Register indexes (byte address = 4 * index)
`define TEC_IDX_PORT1_DIR 16'hFF21
`define TEC_IDX_PORT3_DIR 16'hFF23
`define TEC_IDX_MODE_B 16'hFF43
`define TEC_IDX_MODE_A 16'hFF6B
`define TEC_IDX_CLKSEL_A 16'hFF6A
`define TEC_IDX_CLKSEL_B 16'hFF8C
`define TEC_IDX_COMPARE_A 16'hFF90
`define TEC_IDX_COMPARE_B 16'hFF91
`define TEC_IDX_COUNT_A 16'hFF92
`define TEC_IDX_COUNT_B 16'hFF93
`define TEC_IDX_PORT1_LATCH 16'hFF94
`define TEC_IDX_PORT3_LATCH 16'hFF95

// ========
// Mode control field positions
`define TEC_BIT_RUN 7
`define TEC_BIT_PWM 6
`define TEC_BIT_PRESET_HIGH 3
`define TEC_BIT_PRESET_LOW 2
`define TEC_BIT_INV_POL 1
`define TEC_BIT_OE 0
`define TEC_MODE_STORED_MASK 8'hC3
`define TEC_CLKSEL_MASK 8'h07

// ========
// Reset values
`define TEC_RST_MODE 8'h00
`define TEC_RST_CLKSEL 8'h00
`define TEC_RST_COMPARE 8'h00
`define TEC_RST_DIR 8'hFF
`define TEC_RST_LATCH 8'h00
`define TEC_PORT3_HIGH_ONES 8'hF0

// ========
// Divider exponents of the four slowest clock choices, timer A then B
`define TEC_DIV_A4 4'h2
`define TEC_DIV_A5 4'h6
`define TEC_DIV_A6 4'h8
`define TEC_DIV_A7 4'hD
`define TEC_DIV_B4 4'h4
`define TEC_DIV_B5 4'h6
`define TEC_DIV_B6 4'h8
`define TEC_DIV_B7 4'hC
`define TEC_PRESCALE_W 13

// ========
// Shared-pin bit positions in the port registers
`define TEC_PIN_A_BIT 7
`define TEC_PIN_B_BIT 3

// ========
// Bus constants
`define TEC_ADDR_W 18
`define TEC_RESP_OKAY 2'h0
`define TEC_RESP_SLVERR 2'h2

`endif

// ==== hw/tec_pkg.sv ====
// Types shared by the timer/event counter block
package tec_pkg;

   // ==========================================================
   // Count clock choices
   typedef enum logic [2:0] {
      TEC_CLK_EV_FALL = 3'h0,
      TEC_CLK_EV_RISE = 3'h1,
      TEC_CLK_FULL = 3'h2,
      TEC_CLK_DIV2 = 3'h3,
      TEC_CLK_DIV_S4 = 3'h4,
      TEC_CLK_DIV_S5 = 3'h5,
      TEC_CLK_DIV_S6 = 3'h6,
      TEC_CLK_DIV_S7 = 3'h7
   } tec_clk_sel_t;

   typedef logic [7:0] tec_byte_t;

endpackage : tec_pkg

// ==== hw/tec_timer_pair.sv ====
// Two 8-bit timer/event counters with mode control, pin direction and AXI4-Lite registers
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tec_cfg.svh"

// Contract
// R01 - Run bit low clears and holds counter; high counts on selected clock.
// R02 - Mode bit 6 low gives clear-on-match; high gives free-running PWM.
// R03 - Preset field: 00 keep, 01 flop low, 10 flop high; 11 forbidden.
// R04 - Outside PWM, bit 1 enables flop toggle on each compare match.
// R05 - In PWM, bit 1 selects active level: 0 high, 1 low.
// R06 - Output enable low forces pin low; high passes flop or PWM wave.
// R07 - Preset bits 2 and 3 are write-only and read as zero.
// R08 - Preset field acts only outside PWM mode.
// R09 - Software configures mode, enable, preset, run in separate writes.
// R10 - Software stops the counter before changing the mode bit.
// R11 - In PWM, clearing the run bit drives the output inactive.
// R12 - Mode, preset, polarity and enable affect the pin immediately.
// R13 - Reset clears each mode control register to zero.
// R14 - Mode control accepts single-bit and whole-byte writes.
// R15 - Direction bit 0 means output, 1 input; reset sets all ones.
// R16 - Software sets direction and latch for timer output or event input.
// R17 - Clear-on-match mode: equal count clears, keeps counting, raises match.
// R18 - Interval timer repeats match every compare plus one count clocks.
// R19 - Count clock chosen by bits 0 to 2 of clock select.
// R20 - Event mode counts once per chosen edge of the event input.
// R21 - Software keeps compare value fixed while clear-on-match mode runs.
// R22 - Count rises on count clock; cleared by reset, run low, match.
// R23 - Select codes: falling, rising, undivided clock, then divided clocks.
// R24 - PWM goes active on overflow, inactive on compare, every 256 counts.
// R25 - With inversion on in clear-on-match mode, flop toggles each match.
// R26 - Match request is a one-cycle pulse per compare match.
module tec_timer_pair
   import tec_pkg::*;
(
   // Clock, reset, enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // AXI4-Lite write address
   input wire logic [`TEC_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [`TEC_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Shared pin of timer A
   input wire logic pin_a_i,
   output logic pin_a_o,
   output logic pin_a_oe_n,
   // Shared pin of timer B
   input wire logic pin_b_i,
   output logic pin_b_o,
   output logic pin_b_oe_n,
   // Match requests
   output logic match_irq_a,
   output logic match_irq_b,
   // Port direction state for the rest of the port logic
   output logic [7:0] port1_direction,
   output logic [7:0] port3_direction
);

   // ========
   // Helpers

   // Word index of a byte address
   function automatic logic [15:0] tec_index(input logic [`TEC_ADDR_W-1:0] addr);
      tec_index = addr[`TEC_ADDR_W-1:2];
   endfunction : tec_index

   // True when the index names a register of this block
   function automatic logic tec_mapped(input logic [15:0] idx);
      tec_mapped = (idx == `TEC_IDX_PORT1_DIR) || (idx == `TEC_IDX_PORT3_DIR) ||
         (idx == `TEC_IDX_MODE_A) || (idx == `TEC_IDX_MODE_B) ||
         (idx == `TEC_IDX_CLKSEL_A) || (idx == `TEC_IDX_CLKSEL_B) ||
         (idx == `TEC_IDX_COMPARE_A) || (idx == `TEC_IDX_COMPARE_B) ||
         (idx == `TEC_IDX_COUNT_A) || (idx == `TEC_IDX_COUNT_B) ||
         (idx == `TEC_IDX_PORT1_LATCH) || (idx == `TEC_IDX_PORT3_LATCH);
   endfunction : tec_mapped

   // Divider tick: all low bits of the prescaler set
   function automatic logic tec_div_tick(input logic [`TEC_PRESCALE_W-1:0] psc,
                                         input logic [3:0] shift);
      logic [`TEC_PRESCALE_W-1:0] mask;
      mask = `TEC_PRESCALE_W'((1 << shift) - 1);
      tec_div_tick = ((psc & mask) == mask);
   endfunction : tec_div_tick

   // ========
   // Storage
   tec_byte_t mode [2];
   tec_byte_t clk_sel [2];
   tec_byte_t compare_value [2];
   tec_byte_t count_value [2];
   logic [1:0] wave_flop;
   logic [1:0] pwm_active;
   logic [1:0] ev_prev;
   logic [1:0] match_pulse;
   logic [1:0] tick;
   logic [1:0] ev_pin;
   logic [1:0] wave;
   logic [7:0] port1_latch;
   logic [7:0] port3_latch;
   logic [3:0] port3_dir_low;
   logic [`TEC_PRESCALE_W-1:0] prescale;

   // Bus state
   logic aw_have;
   logic w_have;
   logic [`TEC_ADDR_W-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic do_write;
   logic [15:0] wr_idx;
   logic wr_lane;
   tec_byte_t wr_byte;

   // ========
   // AXI4-Lite write path
   assign s_axi_awready = ce && !aw_have;
   assign s_axi_wready = ce && !w_have;
   assign do_write = ce && aw_have && w_have && !s_axi_bvalid;
   assign wr_idx = tec_index(aw_addr);
   assign wr_lane = w_strb[0];
   assign wr_byte = w_data[7:0];

   // Address and data may arrive in either order; each is held until both are in
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have <= 1'b0;
         w_have <= 1'b0;
         aw_addr <= '0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else if (ce) begin
         if (s_axi_awvalid && !aw_have) begin
            aw_have <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (do_write) begin
            aw_have <= 1'b0;
         end
         if (s_axi_wvalid && !w_have) begin
            w_have <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (do_write) begin
            w_have <= 1'b0;
         end
      end
   end

   // Write response, error on an unmapped word
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `TEC_RESP_OKAY;
      end else if (ce) begin
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= tec_mapped(wr_idx) ? `TEC_RESP_OKAY : `TEC_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ========
   // Register writes; only byte lane 0 carries register data

   // Mode control of each timer; preset bits are never stored
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode[0] <= `TEC_RST_MODE; // see R13
         mode[1] <= `TEC_RST_MODE; // see R13
      end else if (ce && do_write && wr_lane) begin
         // A single-bit update is a read-modify-write of the whole byte
         if (wr_idx == `TEC_IDX_MODE_A) begin
            mode[0] <= wr_byte & `TEC_MODE_STORED_MASK; // see R14 see R07
         end
         if (wr_idx == `TEC_IDX_MODE_B) begin
            mode[1] <= wr_byte & `TEC_MODE_STORED_MASK; // see R14 see R07
         end
      end
   end

   // Clock select and compare registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clk_sel[0] <= `TEC_RST_CLKSEL;
         clk_sel[1] <= `TEC_RST_CLKSEL;
         compare_value[0] <= `TEC_RST_COMPARE;
         compare_value[1] <= `TEC_RST_COMPARE;
      end else if (ce && do_write && wr_lane) begin
         if (wr_idx == `TEC_IDX_CLKSEL_A) clk_sel[0] <= wr_byte & `TEC_CLKSEL_MASK; // see R19
         if (wr_idx == `TEC_IDX_CLKSEL_B) clk_sel[1] <= wr_byte & `TEC_CLKSEL_MASK; // see R19
         if (wr_idx == `TEC_IDX_COMPARE_A) compare_value[0] <= wr_byte;
         if (wr_idx == `TEC_IDX_COMPARE_B) compare_value[1] <= wr_byte;
      end
   end

   // Port direction and output latches
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         port1_direction <= `TEC_RST_DIR; // see R15
         port3_dir_low <= 4'hF; // see R15
         port1_latch <= `TEC_RST_LATCH;
         port3_latch <= `TEC_RST_LATCH;
      end else if (ce && do_write && wr_lane) begin
         if (wr_idx == `TEC_IDX_PORT1_DIR) port1_direction <= wr_byte;
         if (wr_idx == `TEC_IDX_PORT3_DIR) port3_dir_low <= wr_byte[3:0];
         if (wr_idx == `TEC_IDX_PORT1_LATCH) port1_latch <= wr_byte;
         if (wr_idx == `TEC_IDX_PORT3_LATCH) port3_latch <= wr_byte;
      end
   end

   // Upper port 3 bits do not exist and always show input mode
   assign port3_direction = `TEC_PORT3_HIGH_ONES | {4'h0, port3_dir_low};

   // ========
   // Count clock generation

   // Free-running prescaler shared by both timers, so divided ticks stay phase-locked
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prescale <= '0;
      end else if (ce) begin
         prescale <= prescale + `TEC_PRESCALE_W'(1);
      end
   end

   // Event pins are treated as synchronous; the last sample gives the edge
   assign ev_pin[0] = pin_a_i;
   assign ev_pin[1] = pin_b_i;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ev_prev <= 2'h0;
      end else if (ce) begin
         ev_prev <= ev_pin;
      end
   end

   // Tick selection per timer
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         unique case (tec_clk_sel_t'(clk_sel[i][2:0])) // see R19 see R23
            TEC_CLK_EV_FALL: tick[i] = ev_prev[i] && !ev_pin[i]; // see R20
            TEC_CLK_EV_RISE: tick[i] = !ev_prev[i] && ev_pin[i]; // see R20
            TEC_CLK_FULL: tick[i] = 1'b1;
            TEC_CLK_DIV2: tick[i] = tec_div_tick(prescale, 4'h1);
            TEC_CLK_DIV_S4: tick[i] = tec_div_tick(prescale, i == 0 ? `TEC_DIV_A4 : `TEC_DIV_B4);
            TEC_CLK_DIV_S5: tick[i] = tec_div_tick(prescale, i == 0 ? `TEC_DIV_A5 : `TEC_DIV_B5);
            TEC_CLK_DIV_S6: tick[i] = tec_div_tick(prescale, i == 0 ? `TEC_DIV_A6 : `TEC_DIV_B6);
            TEC_CLK_DIV_S7: tick[i] = tec_div_tick(prescale, i == 0 ? `TEC_DIV_A7 : `TEC_DIV_B7);
         endcase
      end
   end

   // ========
   // Counter and match detection
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_value[0] <= 8'h00; // see R22
         count_value[1] <= 8'h00; // see R22
         match_pulse <= 2'h0;
      end else if (ce) begin
         for (int i = 0; i < 2; i++) begin
            match_pulse[i] <= 1'b0; // see R26
            if (!mode[i][`TEC_BIT_RUN]) begin
               count_value[i] <= 8'h00; // see R01 see R22
            end else if (tick[i]) begin
               if (!mode[i][`TEC_BIT_PWM] && count_value[i] == compare_value[i]) begin
                  // Count 0..N then clear: N+1 count clocks per match
                  count_value[i] <= 8'h00; // see R17 see R18 see R02
                  match_pulse[i] <= 1'b1; // see R17 see R26
               end else begin
                  count_value[i] <= count_value[i] + 8'h01; // see R22 see R02
               end
            end
         end
      end
   end

   assign match_irq_a = match_pulse[0];
   assign match_irq_b = match_pulse[1];

   // ========
   // Timer output flip-flop; a preset write wins over a toggle in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wave_flop <= 2'h0;
      end else if (ce) begin
         for (int i = 0; i < 2; i++) begin
            if (do_write && wr_lane && !wr_byte[`TEC_BIT_PWM] && // see R08
                wr_idx == (i == 0 ? `TEC_IDX_MODE_A : `TEC_IDX_MODE_B)) begin
               unique case ({wr_byte[`TEC_BIT_PRESET_HIGH], wr_byte[`TEC_BIT_PRESET_LOW]})
                  2'h1: wave_flop[i] <= 1'b0; // see R03
                  2'h2: wave_flop[i] <= 1'b1; // see R03
                  default: wave_flop[i] <= wave_flop[i]; // see R03
               endcase
            end else if (mode[i][`TEC_BIT_RUN] && tick[i] && !mode[i][`TEC_BIT_PWM] &&
                         mode[i][`TEC_BIT_INV_POL] && count_value[i] == compare_value[i]) begin
               wave_flop[i] <= !wave_flop[i]; // see R04 see R25
            end
         end
      end
   end

   // ========
   // PWM active phase: set at overflow, cleared at compare equality
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pwm_active <= 2'h0;
      end else if (ce) begin
         for (int i = 0; i < 2; i++) begin
            if (!mode[i][`TEC_BIT_RUN] || !mode[i][`TEC_BIT_PWM]) begin
               pwm_active[i] <= 1'b0; // see R11
            end else if (tick[i]) begin
               if (count_value[i] == 8'hFF) begin
                  // A zero compare keeps the wave inactive for the whole period
                  pwm_active[i] <= (compare_value[i] != 8'h00); // see R24
               end else if (count_value[i] + 8'h01 == compare_value[i]) begin
                  pwm_active[i] <= 1'b0; // see R24
               end
            end
         end
      end
   end

   // ========
   // Wave output, combinational from mode bits so changes show at once
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         if (!mode[i][`TEC_BIT_OE]) begin
            wave[i] = 1'b0; // see R06 see R12
         end else if (mode[i][`TEC_BIT_PWM]) begin
            wave[i] = pwm_active[i] ^ mode[i][`TEC_BIT_INV_POL]; // see R05 see R11 see R12
         end else begin
            wave[i] = wave_flop[i]; // see R06 see R12
         end
      end
   end

   // Shared pins: direction bit low turns the driver on; latch must be low for the wave
   assign pin_a_o = wave[0] | port1_latch[`TEC_PIN_A_BIT];
   assign pin_a_oe_n = port1_direction[`TEC_PIN_A_BIT]; // see R15 see R16
   assign pin_b_o = wave[1] | port3_latch[`TEC_PIN_B_BIT];
   assign pin_b_oe_n = port3_dir_low[`TEC_PIN_B_BIT]; // see R15 see R16

   // ========
   // AXI4-Lite read path, one read in flight
   assign s_axi_arready = ce && !s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `TEC_RESP_OKAY;
      end else if (ce) begin
         if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= tec_mapped(tec_index(s_axi_araddr)) ?
                           `TEC_RESP_OKAY : `TEC_RESP_SLVERR;
            unique case (tec_index(s_axi_araddr))
               `TEC_IDX_MODE_A: s_axi_rdata <= {24'h0, mode[0]}; // see R07
               `TEC_IDX_MODE_B: s_axi_rdata <= {24'h0, mode[1]}; // see R07
               `TEC_IDX_CLKSEL_A: s_axi_rdata <= {24'h0, clk_sel[0]};
               `TEC_IDX_CLKSEL_B: s_axi_rdata <= {24'h0, clk_sel[1]};
               `TEC_IDX_COMPARE_A: s_axi_rdata <= {24'h0, compare_value[0]};
               `TEC_IDX_COMPARE_B: s_axi_rdata <= {24'h0, compare_value[1]};
               `TEC_IDX_COUNT_A: s_axi_rdata <= {24'h0, count_value[0]};
               `TEC_IDX_COUNT_B: s_axi_rdata <= {24'h0, count_value[1]};
               `TEC_IDX_PORT1_DIR: s_axi_rdata <= {24'h0, port1_direction};
               `TEC_IDX_PORT3_DIR: s_axi_rdata <= {24'h0, port3_direction};
               `TEC_IDX_PORT1_LATCH: s_axi_rdata <= {24'h0, port1_latch};
               `TEC_IDX_PORT3_LATCH: s_axi_rdata <= {24'h0, port3_latch};
               default: s_axi_rdata <= 32'h0000_0000;
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule : tec_timer_pair

`default_nettype wire

// ==== testbench/tec_timer_pair_asserts.sv ====
// Port checks of the timer pair, bound into every instance
`timescale 1ns/1ps
`default_nettype none
module tec_timer_pair_chk (
   // Clock and enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // Bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   // Pins, requests and directions
   input wire logic pin_a_oe_n,
   input wire logic pin_b_oe_n,
   input wire logic match_irq_a,
   input wire logic match_irq_b,
   input wire logic [7:0] port1_direction,
   input wire logic [7:0] port3_direction
);
   // ========
   // One clock domain, so clocking and reset are set once
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   chk_dir_reset: assert property ($past(!aresetn) |-> port1_direction == 8'hFF)
      else $error("port 1 direction not all ones after reset");
   chk_p3_upper: assert property (port3_direction[7:4] == 4'hF)
      else $error("port 3 upper direction bits not ones");
   chk_oe_follows: assert property (
      pin_a_oe_n == port1_direction[7] && pin_b_oe_n == port3_direction[3])
      else $error("pin enable differs from direction bit");
   chk_irq_a_pulse: assert property (match_irq_a |=> !match_irq_a)
      else $error("timer A match request longer than one cycle");
   chk_irq_b_pulse: assert property ($rose(match_irq_b) |=> $fell(match_irq_b))
      else $error("timer B match request longer than one cycle");
   // A frozen block must not take bus requests it cannot store
   chk_ready_ce: assert property (!ce |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
      else $error("ready high while enable low");
   chk_wr_answer: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
endmodule : tec_timer_pair_chk

bind tec_timer_pair tec_timer_pair_chk chk_u (.*);
`default_nettype wire

// ==== testbench/tec_event_src.sv ====
// Event source and pin load on the far side of both timers
`timescale 1ns/1ps
`default_nettype none
module tec_event_src (
   // Clock
   input wire logic aclk,
   // Timer A pin
   input wire logic pin_a_o,
   input wire logic pin_a_oe_n,
   output logic pin_a_i,
   // Timer B pin
   input wire logic pin_b_o,
   input wire logic pin_b_oe_n,
   output logic pin_b_i
);
   // ========
   // Event lines, low between pulses
   logic ev_a = 1'b0;
   logic ev_b = 1'b0;
   // A driving timer owns the wire; the source is heard only with the buffer off
   assign pin_a_i = pin_a_oe_n ? ev_a : pin_a_o;
   assign pin_b_i = pin_b_oe_n ? ev_b : pin_b_o;
   // Pulse train, each phase w clocks wide, so prompt and slow events both occur
   task automatic pulses(input bit b, input int n, input int w);
      repeat (n) begin
         repeat (w) @(posedge aclk);
         if (b) ev_b <= 1'b1;
         else ev_a <= 1'b1;
         repeat (w) @(posedge aclk);
         if (b) ev_b <= 1'b0;
         else ev_a <= 1'b0;
      end
   endtask : pulses
endmodule : tec_event_src
`default_nettype wire

// ==== testbench/tb_eight_bit_timer_event_counter_ctrl.sv ====
// Self-checking bench of the timer pair
`timescale 1ns/1ps
`default_nettype none
`include "tec_cfg.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; \
   $display("mismatch at %0t: got %h expected %h", $time, (a), (b)); end end
module tb_eight_bit_timer_event_counter_ctrl import tec_pkg::*;;
   // ========
   // Indexes, responses and the output table
   localparam logic [15:0] MA = `TEC_IDX_MODE_A, MB = `TEC_IDX_MODE_B;
   localparam logic [15:0] D1 = `TEC_IDX_PORT1_DIR, D3 = `TEC_IDX_PORT3_DIR;
   localparam logic [15:0] CSA = `TEC_IDX_CLKSEL_A, CSB = `TEC_IDX_CLKSEL_B;
   localparam logic [15:0] CPA = `TEC_IDX_COMPARE_A, CPB = `TEC_IDX_COMPARE_B;
   localparam logic [15:0] CNA = `TEC_IDX_COUNT_A, CNB = `TEC_IDX_COUNT_B;
   localparam logic [1:0] OK = `TEC_RESP_OKAY, ER = `TEC_RESP_SLVERR;
   localparam tec_byte_t TM [10] = '{8'h01, 8'h09, 8'h00, 8'h01, 8'h05,
                                     8'h09, 8'h41, 8'h43, 8'h45, 8'h01};
   // ========
   // Signals and bench state
   logic aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, irq_a, irq_b;
   logic pa_i, pa_o, pa_oe_n, pb_i, pb_o, pb_oe_n;
   logic [`TEC_ADDR_W-1:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   tec_byte_t dir1, dir3, d, n;
   int n_errors = 0;
   int compares = 0;
   int nirq [2] = '{0, 0};
   int c, s;
   logic [33:0] expq [$];
   logic [33:0] exp_e;
   tec_timer_pair dut_u (
      .aclk(aclk), .aresetn(aresetn), .ce(ce),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .pin_a_i(pa_i), .pin_a_o(pa_o), .pin_a_oe_n(pa_oe_n),
      .pin_b_i(pb_i), .pin_b_o(pb_o), .pin_b_oe_n(pb_oe_n),
      .match_irq_a(irq_a), .match_irq_b(irq_b), .port1_direction(dir1), .port3_direction(dir3)
   );
   tec_event_src src_u (
      .aclk(aclk), .pin_a_o(pa_o), .pin_a_oe_n(pa_oe_n), .pin_a_i(pa_i),
      .pin_b_o(pb_o), .pin_b_oe_n(pb_oe_n), .pin_b_i(pb_i)
   );
   // 50 MHz clock
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end
   // Read answers are checked against the oldest note; irqs are tallied
   always @(posedge aclk) begin
      if (irq_a) nirq[0]++;
      if (irq_b) nirq[1]++;
      if (rvalid && rready) begin
         exp_e = expq.pop_front();
         `CHK({rresp, rdata}, exp_e);
      end
   end
   // A hang ends the run through the same verdict
   initial begin
      #400000;
      n_errors++;
      test_done();
   end
   // ========
   // Helpers
   task test_done;
      $display("errors %0d, compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : test_done
   // Address and data offered together; bready stays high throughout
   task automatic wr(input logic [15:0] i, input tec_byte_t v, input logic [1:0] r = OK);
      logic a, w;
      a = 1'b0;
      w = 1'b0;
      awaddr <= {i, 2'h0};
      wdata <= {24'h0, v};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(a && w)) begin
         @(posedge aclk);
         if (awvalid && awready) begin
            a = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready) begin
            w = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      `CHK(bresp, r);
   endtask : wr
   task automatic rd(input logic [15:0] i, input tec_byte_t v, input logic [1:0] r = OK);
      expq.push_back({r, 24'h0, v});
      araddr <= {i, 2'h0};
      arvalid <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
   endtask : rd
   // 0 and 1 pick a match request, 2 and 3 a pin level
   function automatic logic pick(input int k);
      return k == 0 ? irq_a : k == 1 ? irq_b : k == 2 ? pa_o : pb_o;
   endfunction : pick
   task automatic wait_on(input int k, input logic v, output int cy);
      cy = 0;
      do begin
         @(posedge aclk);
         cy++;
      end while (pick(k) !== v && cy < 2000);
   endtask : wait_on
   // Interval run: per is the number of clocks in one count tick
   task automatic ivl(input int b, input tec_byte_t sel, input tec_byte_t cv, input int per);
      logic p;
      int k;
      wr(b ? CSB : CSA, sel);
      wr(b ? CPB : CPA, cv);
      wr(b ? MB : MA, 8'h02);
      wr(b ? MB : MA, 8'h03);
      wr(b ? MB : MA, 8'h07);
      wr(b ? MB : MA, 8'h83);
      wait_on(b, 1'b1, k);
      p = pick(b + 2);
      wait_on(b, 1'b1, k);
      `CHK(k, (cv + 1) * per);
      `CHK(pick(b + 2), ~p);
      wr(b ? MB : MA, 8'h03);
      repeat (2) @(posedge aclk);
      k = nirq[b];
      repeat (2 * (cv + 1) * per) @(posedge aclk);
      `CHK(nirq[b], k);
      rd(b ? CNB : CNA, 8'h00);
   endtask : ivl
   // ========
   // Main sequence
   initial begin
      {ce, bready, rready, wstrb} = 7'h7F;
      {aresetn, awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
      void'($urandom(13));
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(MA, 8'h00);
      rd(MB, 8'h00);
      rd(D1, 8'hFF);
      rd(D3, 8'hFF);
      wr(16'h0000, 8'h5A, ER);
      rd(16'h0000, 8'h00, ER);
      ce <= 1'b0;
      repeat (3) @(posedge aclk);
      ce <= 1'b1;
      // Random mode byte reads back without preset and unused bits
      d = 8'($urandom) & 8'h77;
      wr(MB, d);
      rd(MB, d & 8'hC3);
      wr(MB, 8'h00);
      wr(D3, 8'h00);
      rd(D3, 8'hF0);
      wr(D3, 8'hF7);
      // Falling then rising edge events, four per match at compare 3
      for (s = 0; s < 2; s++) begin
         wr(MA, 8'h00);
         wr(CSA, 8'(s));
         wr(CPA, 8'h03);
         wr(MA, 8'h80);
         c = nirq[0];
         src_u.pulses(1'b0, 8, 2 + 3 * s);
         repeat (4) @(posedge aclk);
         `CHK(nirq[0] - c, 2);
      end
      // Preset, enable and polarity reach the pin at once, counter stopped
      wr(D1, 8'h7F);
      for (s = 0; s < 10; s++) begin
         wr(MA, TM[s]);
         @(posedge aclk);
         `CHK(pa_o, s[0]);
      end
      ivl(0, 8'h02, 8'h01 + 8'($urandom % 254), 1);
      ivl(1, 8'h03, 8'h01 + 8'($urandom % 16), 2);
      ivl(1, 8'h04, 8'h01 + 8'($urandom % 8), 16);
      // PWM: active width follows compare, period 256, stop while active
      n = 8'h40 + 8'($urandom % 128);
      wr(CPA, n);
      wr(MA, 8'h41);
      wr(MA, 8'hC1);
      wait_on(2, 1'b1, c);
      wait_on(2, 1'b0, c);
      `CHK(c, int'(n));
      wait_on(2, 1'b1, c);
      `CHK(c, 256 - int'(n));
      wr(MA, 8'h41);
      @(posedge aclk);
      `CHK(pa_o, 1'b0);
      test_done();
   end
endmodule : tb_eight_bit_timer_event_counter_ctrl
`default_nettype wire
